// File: rtl/ctp_trigger.sv
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "ctp_map.svh"

// Notes on behaviour
// - Overlap bit picks overlapped mode or standard exposure-then-readout mode.
// - Software trigger command produces one short internal trigger pulse.
// - Active edge is rising or falling; only that edge triggers.
// - Width exposure, rising edge: expose exactly while the trigger is high.
// - Width exposure, falling edge: expose exactly while the trigger is low.
// - Pulses narrower than the filter setting are rejected; up to 65535 us.
// - After an accepted trigger, pulses are ignored for the lockout interval.
// - Exposure starts the programmed delay after the trigger; up to 16777215 us.
// - Filter and lockout act on the two external input lines.
// - Pulser triggers only while its enable bit is set.
// - Pulser emits a burst of 1 to 65535 pulses or runs continuously.
// - Pulser width and period count in units of 1, 10, 100, 1000 cycles.
// - Each generated pulse stays high for the programmed width, then low.
// - Generated pulses are spaced by the programmed period.
// - Pulser waveform serves as trigger source and as output line signal.
// - Each input line has a polarity inversion before trigger use.
// - Each output line picks one of nine signals, optionally inverted.
// - A trigger arriving before the current trigger period ends is ignored.
// - Exposure start, middle and end indications on the output lines are fixed 10 us pulses; the start and end ports pulse for one cycle.
module ctp_trigger (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic trig_line1_in,
  input wire logic trig_line2_in,
  input wire logic grabber_link_trig_in,
  input wire logic readout_busy_in,
  input wire logic strobe1_in,
  input wire logic strobe2_in,
  output logic exposure_active_out,
  output logic exposure_start_out,
  output logic exposure_end_out,
  output logic line_out1_out,
  output logic line_out2_out
);
  import ctp_pkg::*;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a[1:0] == 2'h0) && (a <= `CTP_OFF_STATUS);
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    wmerge = m;
  endfunction

  function automatic logic out_pick(input logic [8:0] s, input logic [3:0] sel);
    out_pick = (sel <= 4'h8) ? s[sel] : 1'b0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic [1:0] rst_sync_r;
  wire rst_n = rst_sync_r[1];
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and AXI4-Lite slave
  logic [`CTP_CTRL_BITS-1:0] ctrl_r;
  logic [15:0] filt_r;
  logic [15:0] lock_r;
  logic [23:0] dly_r;
  logic [23:0] exp_r;
  logic [31:0] pgc_r;
  logic [15:0] pgw_r;
  logic [15:0] pgp_r;
  logic sw_pulse_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic [31:0] status_w;
  logic [31:0] rd_mux;

  wire do_wr = aw_hold_r && w_hold_r;
  wire wr_ok = do_wr && addr_known(aw_addr_r);
  wire [31:0] wm_ctrl = wmerge({13'h0000, ctrl_r}, w_data_r, w_strb_r);
  wire [31:0] wm_filt = wmerge({16'h0000, filt_r}, w_data_r, w_strb_r);
  wire [31:0] wm_lock = wmerge({16'h0000, lock_r}, w_data_r, w_strb_r);
  wire [31:0] wm_dly = wmerge({8'h00, dly_r}, w_data_r, w_strb_r);
  wire [31:0] wm_exp = wmerge({8'h00, exp_r}, w_data_r, w_strb_r);
  wire [31:0] wm_pgc = wmerge(pgc_r, w_data_r, w_strb_r);
  wire [31:0] wm_pgw = wmerge({16'h0000, pgw_r}, w_data_r, w_strb_r);
  wire [31:0] wm_pgp = wmerge({16'h0000, pgp_r}, w_data_r, w_strb_r);
  wire wr_sw = wr_ok && (aw_addr_r == `CTP_OFF_SWTRIG) && w_strb_r[0] && w_data_r[0];

  assign s_axi_awready_out = !aw_hold_r && !bvalid_r;
  assign s_axi_wready_out = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign s_axi_arready_out = !rvalid_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rresp_out = rresp_r;
  assign s_axi_rdata_out = rdata_r;

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata_in;
        w_strb_r <= s_axi_wstrb_in;
      end
      if (do_wr) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= addr_known(aw_addr_r) ? 2'h0 : 2'h3;
      end else if (s_axi_bready_in) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `CTP_RST_CTRL;
      filt_r <= `CTP_RST_FILTER;
      lock_r <= `CTP_RST_LOCKOUT;
      dly_r <= `CTP_RST_DELAY;
      exp_r <= `CTP_RST_EXPTIME;
      pgc_r <= `CTP_RST_PG_CTRL;
      pgw_r <= `CTP_RST_PG_WIDTH;
      pgp_r <= `CTP_RST_PG_PERIOD;
      sw_pulse_r <= 1'b0;
    end else begin
      sw_pulse_r <= wr_sw;
      if (wr_ok) begin
        unique case (aw_addr_r)
          `CTP_OFF_CTRL: ctrl_r <= wm_ctrl[`CTP_CTRL_BITS-1:0];
          `CTP_OFF_FILTER: filt_r <= wm_filt[15:0];
          `CTP_OFF_LOCKOUT: lock_r <= wm_lock[15:0];
          `CTP_OFF_DELAY: dly_r <= wm_dly[23:0];
          `CTP_OFF_EXPTIME: exp_r <= wm_exp[23:0];
          `CTP_OFF_PG_CTRL: pgc_r <= {wm_pgc[31:16], 12'h000, wm_pgc[3:0]};
          `CTP_OFF_PG_WIDTH: pgw_r <= wm_pgw[15:0];
          `CTP_OFF_PG_PERIOD: pgp_r <= wm_pgp[15:0];
          default: ;
        endcase
      end
    end
  end

  assign rd_mux =
    (s_axi_araddr_in == `CTP_OFF_CTRL) ? {13'h0000, ctrl_r} :
    (s_axi_araddr_in == `CTP_OFF_FILTER) ? {16'h0000, filt_r} :
    (s_axi_araddr_in == `CTP_OFF_LOCKOUT) ? {16'h0000, lock_r} :
    (s_axi_araddr_in == `CTP_OFF_DELAY) ? {8'h00, dly_r} :
    (s_axi_araddr_in == `CTP_OFF_EXPTIME) ? {8'h00, exp_r} :
    (s_axi_araddr_in == `CTP_OFF_PG_CTRL) ? pgc_r :
    (s_axi_araddr_in == `CTP_OFF_PG_WIDTH) ? {16'h0000, pgw_r} :
    (s_axi_araddr_in == `CTP_OFF_PG_PERIOD) ? {16'h0000, pgp_r} :
    (s_axi_araddr_in == `CTP_OFF_STATUS) ? status_w : 32'h00000000;

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rresp_r <= 2'h0;
      rdata_r <= 32'h00000000;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      rvalid_r <= 1'b1;
      rresp_r <= addr_known(s_axi_araddr_in) ? 2'h0 : 2'h3;
      rdata_r <= rd_mux;
    end else if (s_axi_rready_in) begin
      rvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and pulser
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic pg_pulse;
  logic pg_busy;
  wire [2:0] raw_in = {grabber_link_trig_in, trig_line2_in, trig_line1_in};
  generate
    for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
          sync1_r[i] <= 1'b0;
          sync2_r[i] <= 1'b0;
        end else begin
          sync1_r[i] <= raw_in[i];
          sync2_r[i] <= sync1_r[i];
        end
      end
    end
  endgenerate

  ctp_pulser u_pulser (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n),
    .pulser_on_in(pgc_r[`CTP_PG_ON]),
    .continuous_in(pgc_r[`CTP_PG_CONT]),
    .gran_in(pgc_r[`CTP_PG_GRAN_LSB +: 2]),
    .count_in(pgc_r[`CTP_PG_COUNT_LSB +: 16]),
    .width_in(pgw_r),
    .period_in(pgp_r),
    .pulse_out(pg_pulse),
    .busy_out(pg_busy)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Source selection, edge, filter and lockout
  wire trig_enable = ctrl_r[`CTP_CTRL_TRIG_EN];
  wire exposure_overlap_select = ctrl_r[`CTP_CTRL_OVERLAP];
  wire [2:0] trig_origin_select = ctrl_r[`CTP_CTRL_ORIGIN_LSB +: 3];
  wire trig_edge_select = ctrl_r[`CTP_CTRL_EDGE_FALL];
  wire level_duration_exposure = ctrl_r[`CTP_CTRL_WIDTH_MODE];
  wire line1_lvl = sync2_r[0] ^ ctrl_r[`CTP_CTRL_INV_IN1];
  wire line2_lvl = sync2_r[1] ^ ctrl_r[`CTP_CTRL_INV_IN2];
  wire is_line = (trig_origin_select == CTP_SRC_LINE1) || (trig_origin_select == CTP_SRC_LINE2);
  wire src_lvl =
    (trig_origin_select == CTP_SRC_LINE1) ? line1_lvl :
    (trig_origin_select == CTP_SRC_LINE2) ? line2_lvl :
    (trig_origin_select == CTP_SRC_SOFT) ? sw_pulse_r :
    (trig_origin_select == CTP_SRC_PULSER) ? (pg_pulse && pgc_r[`CTP_PG_ON]) :
    (trig_origin_select == CTP_SRC_LINK) ? sync2_r[2] : 1'b0;
  wire act_lvl = src_lvl ^ trig_edge_select;

  logic act_d_r;
  logic filt_ok_d_r;
  logic [6:0] us_pre_r;
  logic [15:0] filt_cnt_r;
  logic [15:0] lock_cnt_r;
  wire us_tick = (us_pre_r == 7'(`CTP_CYC_PER_US - 1));
  wire filt_ok = act_lvl && (filt_cnt_r >= filt_r);
  wire lock_busy = is_line && (lock_cnt_r != 16'h0000);
  wire cand = is_line ? (filt_ok && !filt_ok_d_r) : (act_lvl && !act_d_r);
  logic accept;

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      us_pre_r <= 7'h00;
      act_d_r <= 1'b0;
      filt_ok_d_r <= 1'b0;
      filt_cnt_r <= 16'h0000;
      lock_cnt_r <= 16'h0000;
    end else begin
      us_pre_r <= us_tick ? 7'h00 : us_pre_r + 7'h01;
      act_d_r <= act_lvl;
      filt_ok_d_r <= filt_ok;
      if (!act_lvl) begin
        filt_cnt_r <= 16'h0000;
      end else if (us_tick && !filt_ok) begin
        filt_cnt_r <= filt_cnt_r + 16'h0001;
      end
      if (accept) begin
        lock_cnt_r <= lock_r;
      end else if (us_tick && lock_cnt_r != 16'h0000) begin
        lock_cnt_r <= lock_cnt_r - 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Exposure sequencer
  ctp_state_t st_r;
  ctp_state_t st_nxt;
  logic [23:0] tcnt_r;
  wire in_idle = (st_r == CTP_ST_IDLE);
  wire period_done = in_idle && (exposure_overlap_select || !readout_busy_in);
  wire dly_done = (st_r == CTP_ST_DELAY) && (tcnt_r >= dly_r);
  wire exp_done = level_duration_exposure ? !act_lvl : (tcnt_r >= exp_r);
  wire exp_end = (st_r == CTP_ST_EXPOSE) && exp_done;
  wire exp_mid = (st_r == CTP_ST_EXPOSE) && !level_duration_exposure && us_tick &&
                 (tcnt_r == {1'b0, exp_r[23:1]});
  assign accept = trig_enable && cand && !lock_busy && period_done;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      CTP_ST_IDLE: if (accept) st_nxt = CTP_ST_DELAY;
      CTP_ST_DELAY: if (dly_done) st_nxt = CTP_ST_EXPOSE;
      CTP_ST_EXPOSE: if (exp_done) st_nxt = exposure_overlap_select ? CTP_ST_IDLE : CTP_ST_READOUT;
      CTP_ST_READOUT: if (!readout_busy_in) st_nxt = CTP_ST_IDLE;
      default: st_nxt = CTP_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= CTP_ST_IDLE;
      tcnt_r <= 24'h000000;
    end else begin
      st_r <= st_nxt;
      if (st_nxt != st_r) begin
        tcnt_r <= 24'h000000;
      end else if (us_tick) begin
        tcnt_r <= tcnt_r + 24'h000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Indication pulses and output lines
  wire exp_start = dly_done;
  wire [3:0] ind_ev = {dly_done, exp_mid, exp_end, exp_start};
  logic [3:0] ind_lvl;
  logic [1:0] line_r;
  logic exp_start_r;
  logic exp_end_r;
  generate
    for (genvar i = 0; i < 4; i++) begin : g_ind
      logic [9:0] ind_cnt_r;
      always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
          ind_cnt_r <= 10'h000;
        end else if (ind_ev[i]) begin
          ind_cnt_r <= 10'(`CTP_IND_PULSE_CYC);
        end else if (ind_cnt_r != 10'h000) begin
          ind_cnt_r <= ind_cnt_r - 10'h001;
        end
      end
      assign ind_lvl[i] = (ind_cnt_r != 10'h000);
    end
  endgenerate

  wire [8:0] sig9 = {strobe2_in, strobe1_in, pg_pulse, ind_lvl[3], src_lvl,
                     st_r == CTP_ST_EXPOSE, ind_lvl[2], ind_lvl[1], ind_lvl[0]};
  wire [1:0] out_inv = {ctrl_r[`CTP_CTRL_INV_OUT2], ctrl_r[`CTP_CTRL_INV_OUT1]};
  wire [7:0] out_sel = {ctrl_r[`CTP_CTRL_SEL_OUT2_LSB +: 4], ctrl_r[`CTP_CTRL_SEL_OUT1_LSB +: 4]};
  generate
    for (genvar k = 0; k < 2; k++) begin : g_out
      always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
          line_r[k] <= 1'b0;
        end else begin
          line_r[k] <= out_pick(sig9, out_sel[k*4 +: 4]) ^ out_inv[k];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      exp_start_r <= 1'b0;
      exp_end_r <= 1'b0;
    end else begin
      exp_start_r <= exp_start;
      exp_end_r <= exp_end;
    end
  end

  assign status_w = {22'h000000, lock_busy, pg_busy, 4'(st_r), 3'h0, st_r == CTP_ST_EXPOSE};
  assign line_out1_out = line_r[0];
  assign line_out2_out = line_r[1];
  assign exposure_start_out = exp_start_r;
  assign exposure_end_out = exp_end_r;
  assign exposure_active_out = (st_r == CTP_ST_EXPOSE);

endmodule

// File: shared/ctp_map.svh
`ifndef CTP_MAP_SVH
`define CTP_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// Timing
`define CTP_CLK_PERIOD_NS 10
`define CTP_CYC_PER_US (1000 / `CTP_CLK_PERIOD_NS)
`define CTP_IND_PULSE_US 10
`define CTP_IND_PULSE_CYC (`CTP_IND_PULSE_US * `CTP_CYC_PER_US)

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define CTP_OFF_CTRL 8'h00
`define CTP_OFF_FILTER 8'h04
`define CTP_OFF_LOCKOUT 8'h08
`define CTP_OFF_DELAY 8'h0c
`define CTP_OFF_EXPTIME 8'h10
`define CTP_OFF_PG_CTRL 8'h14
`define CTP_OFF_PG_WIDTH 8'h18
`define CTP_OFF_PG_PERIOD 8'h1c
`define CTP_OFF_SWTRIG 8'h20
`define CTP_OFF_STATUS 8'h24

////////////////////////////////////////////////////////////////////////////////
// Control fields
`define CTP_CTRL_TRIG_EN 0
`define CTP_CTRL_OVERLAP 1
`define CTP_CTRL_ORIGIN_LSB 2
`define CTP_CTRL_EDGE_FALL 5
`define CTP_CTRL_WIDTH_MODE 6
`define CTP_CTRL_INV_IN1 7
`define CTP_CTRL_INV_IN2 8
`define CTP_CTRL_INV_OUT1 9
`define CTP_CTRL_INV_OUT2 10
`define CTP_CTRL_SEL_OUT1_LSB 11
`define CTP_CTRL_SEL_OUT2_LSB 15
`define CTP_CTRL_BITS 19
`define CTP_PG_ON 0
`define CTP_PG_CONT 1
`define CTP_PG_GRAN_LSB 2
`define CTP_PG_COUNT_LSB 16

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define CTP_RST_CTRL 19'h00000
`define CTP_RST_FILTER 16'h0000
`define CTP_RST_LOCKOUT 16'h0000
`define CTP_RST_DELAY 24'h000000
`define CTP_RST_EXPTIME 24'h0003e8
`define CTP_RST_PG_CTRL 32'h00010000
`define CTP_RST_PG_WIDTH 16'h0001
`define CTP_RST_PG_PERIOD 16'h0002

`endif

// File: shared/ctp_pkg.sv
package ctp_pkg;

  typedef enum logic [3:0] {
    CTP_ST_IDLE = 4'b0001,
    CTP_ST_DELAY = 4'b0010,
    CTP_ST_EXPOSE = 4'b0100,
    CTP_ST_READOUT = 4'b1000
  } ctp_state_t;

  typedef enum logic [2:0] {
    CTP_SRC_LINE1 = 3'h0,
    CTP_SRC_LINE2 = 3'h1,
    CTP_SRC_SOFT = 3'h2,
    CTP_SRC_PULSER = 3'h3,
    CTP_SRC_LINK = 3'h4
  } ctp_origin_t;

  typedef enum logic [3:0] {
    CTP_OUT_EXP_START = 4'h0,
    CTP_OUT_EXP_END = 4'h1,
    CTP_OUT_EXP_MID = 4'h2,
    CTP_OUT_EXP_ACTIVE = 4'h3,
    CTP_OUT_TRIG_ACTUAL = 4'h4,
    CTP_OUT_TRIG_DELAYED = 4'h5,
    CTP_OUT_PULSER = 4'h6,
    CTP_OUT_STROBE1 = 4'h7,
    CTP_OUT_STROBE2 = 4'h8
  } ctp_outsel_t;

  typedef logic [1:0] ctp_gran_t;

endpackage

// File: rtl/ctp_pulser.sv
`timescale 1ns/100ps
`include "ctp_map.svh"

module ctp_pulser (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic pulser_on_in,
  input wire logic continuous_in,
  input wire ctp_pkg::ctp_gran_t gran_in,
  input wire logic [15:0] count_in,
  input wire logic [15:0] width_in,
  input wire logic [15:0] period_in,
  output logic pulse_out,
  output logic busy_out
);
  import ctp_pkg::*;

  function automatic logic [9:0] gran_last(input ctp_gran_t g);
    case (g)
      2'h0: gran_last = 10'h000;
      2'h1: gran_last = 10'h009;
      2'h2: gran_last = 10'h063;
      default: gran_last = 10'h3e7;
    endcase
  endfunction

  logic en_d_r;
  logic run_r;
  logic pulse_r;
  logic [9:0] pre_r;
  logic [15:0] ph_r;
  logic [15:0] rem_r;
  wire start = pulser_on_in && !en_d_r;
  wire unit_tick = (pre_r == gran_last(gran_in));
  wire period_end = ({1'b0, ph_r} + 17'h00001) >= {1'b0, period_in};
  wire last_pulse = !continuous_in && (rem_r <= 16'h0001);

  ////////////////////////////////////////////////////////////////////////////////
  // Unit prescaler and phase
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en_d_r <= 1'b0;
      run_r <= 1'b0;
      pre_r <= 10'h000;
      ph_r <= 16'h0000;
      rem_r <= 16'h0000;
      pulse_r <= 1'b0;
    end else begin
      en_d_r <= pulser_on_in;
      pulse_r <= run_r && (ph_r < width_in);
      if (start) begin
        run_r <= 1'b1;
        rem_r <= count_in;
        pre_r <= 10'h000;
        ph_r <= 16'h0000;
      end else if (!pulser_on_in) begin
        run_r <= 1'b0;
      end else if (run_r) begin
        pre_r <= unit_tick ? 10'h000 : pre_r + 10'h001;
        if (unit_tick && period_end) begin
          ph_r <= 16'h0000;
          rem_r <= rem_r - 16'h0001;
          if (last_pulse) begin
            run_r <= 1'b0;
          end
        end else if (unit_tick) begin
          ph_r <= ph_r + 16'h0001;
        end
      end
    end
  end

  assign pulse_out = pulse_r;
  assign busy_out = run_r;

endmodule

// File: test/ctp_trigger_properties.sv
`timescale 1ns/100ps
module ctp_trigger_chk (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic exposure_active_out,
  input wire logic exposure_start_out,
  input wire logic exposure_end_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_ar; s_axi_arvalid_in && s_axi_arready_out; endsequence
  sequence s_exp_fall; $fell(exposure_active_out); endsequence
  property p_rd_ans; s_ar |=> s_axi_rvalid_out; endproperty
  property p_rd_hold;
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  property p_rd_block; s_axi_rvalid_out |-> !s_axi_arready_out; endproperty
  property p_wr_hold;
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
  endproperty
  property p_wr_block; s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out; endproperty
  property p_start_one; exposure_start_out |=> !exposure_start_out; endproperty
  property p_start_exp; exposure_start_out |-> ##[0:2] exposure_active_out; endproperty
  property p_end_after; s_exp_fall |-> ##[0:2] exposure_end_out; endproperty
  property p_end_idle; exposure_end_out |-> !exposure_active_out; endproperty
  ////////////////////////////////////////////////////////////////////////////////
  a_rd_ans: assert property (p_rd_ans)
    else $error("Read not answered");
  a_rd_hold: assert property (p_rd_hold)
    else $error("Read data dropped");
  a_rd_block: assert property (p_rd_block)
    else $error("Read address taken while busy");
  a_wr_hold: assert property (p_wr_hold)
    else $error("Write response dropped");
  a_wr_block: assert property (p_wr_block)
    else $error("Write taken while busy");
  a_start_one: assert property (p_start_one)
    else $error("Start pulse too long");
  a_start_exp: assert property (p_start_exp)
    else $error("Start without exposure");
  a_end_after: assert property (p_end_after)
    else $error("No end pulse");
  a_end_idle: assert property (p_end_idle)
    else $error("End pulse while exposing");
endmodule

// File: test/ctp_trig_src.sv
`timescale 1ns/100ps
module ctp_trig_src (
  input wire logic clk_sys_in,
  output logic line_out
);
  initial line_out = 1'b0;
  // Idle at the inverse level, then one pulse of w cycles
  task automatic pulse(input logic act, input int w);
    @(posedge clk_sys_in) line_out <= !act;
    repeat (50) @(posedge clk_sys_in);
    line_out <= act;
    repeat (w) @(posedge clk_sys_in);
    line_out <= !act;
  endtask
endmodule

// File: test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import ctp_pkg::*;
  logic clk_sys_in = 0, rst_b_in = 0, awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0;
  logic [7:0] aw = 0, ar = 0;
  logic [31:0] wd = 0, rdat, dat, v;
  logic awr, wrdy, bv, arr, rv, ea, es, ee, o1, o2, line1, p2, lnk;
  logic [1:0] bresp, rresp, resp;
  int fails = 0, tests_run = 0, ne, n1, n2, r2, ns, nend;
  logic [103:0] tab [10] = '{
    {8'h00, 32'h0007fffe, 32'h0, 32'h0007fffe}, {8'h04, 32'hffffffff, 32'h0, 32'h0000ffff},
    {8'h08, 32'hffffffff, 32'h0, 32'h0000ffff}, {8'h0c, 32'hffffffff, 32'h0, 32'h00ffffff},
    {8'h10, 32'h2, 32'h3e8, 32'h2}, {8'h14, 32'hfffffffe, 32'h00010000, 32'hffff000e},
    {8'h18, 32'h3, 32'h1, 32'h3}, {8'h1c, 32'h5, 32'h2, 32'h5},
    {8'h20, 32'h1, 32'h0, 32'h0}, {8'h28, 32'hffffffff, 32'h0, 32'h0}};
  ctp_trig_src src_u (.clk_sys_in(clk_sys_in), .line_out(line1));
  ctp_trig_src lnk_u (.clk_sys_in(clk_sys_in), .line_out(lnk));
  ctp_trigger dut_u (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .s_axi_awaddr_in(aw), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(brd), .s_axi_araddr_in(ar), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rrd), .trig_line1_in(line1),
    .trig_line2_in(1'b0), .grabber_link_trig_in(lnk), .readout_busy_in(1'b0),
    .strobe1_in(1'b0), .strobe2_in(1'b0), .exposure_active_out(ea),
    .exposure_start_out(es), .exposure_end_out(ee), .line_out1_out(o1), .line_out2_out(o2));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [95:0] g, input logic [95:0] e);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      fails++;
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge clk_sys_in);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    do begin
      @(negedge clk_sys_in);
      ta = awv && awr;
      tw = wv && wrdy;
      tb = bv;
      resp = bresp;
      @(posedge clk_sys_in);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!tb);
    brd <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge clk_sys_in);
    ar <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    do begin
      @(negedge clk_sys_in);
      ta = arv && arr;
      tr = rv;
      dat = rdat;
      resp = rresp;
      @(posedge clk_sys_in);
      if (ta) arv <= 1'b0;
    end while (!tr);
    rrd <= 1'b0;
  endtask
  task automatic watch(input int win);
    ne = 0;
    n1 = 0;
    n2 = 0;
    r2 = 0;
    ns = 0;
    nend = 0;
    p2 = o2;
    repeat (win) begin
      @(negedge clk_sys_in);
      ne += ea;
      n1 += o1;
      n2 += o2;
      ns += es;
      nend += ee;
      r2 += (o2 && !p2);
      p2 = o2;
    end
  endtask
  task report_and_stop;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    #300000;
    fails++;
    report_and_stop;
  end
  initial begin
    repeat (2) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    for (int i = 0; i < 10; i++) begin
      axi_rd(tab[i][103:96]);
      chk(dat, tab[i][63:32]);
      axi_wr(tab[i][103:96], tab[i][95:64]);
      chk(resp, (tab[i][103:96] > 8'h24) ? 32'h3 : 32'h0);
      axi_rd(tab[i][103:96]);
      chk({resp, dat}, {(tab[i][103:96] > 8'h24) ? 2'h3 : 2'h0, tab[i][31:0]});
    end
    axi_wr(8'h0c, 32'h0);
    axi_wr(8'h04, 32'h5);
    axi_wr(8'h08, 32'h0);
    axi_wr(8'h00, 32'h0000000b);
    fork axi_wr(8'h20, 32'h1); watch(1500); join
    chk({ns, nend, n1}, {32'h1, 32'h1, 32'd1000});
    chk(ne >= 101 && ne <= 201, 1);
    axi_wr(8'h08, 32'h32);
    axi_wr(8'h00, 32'h00000003);
    fork src_u.pulse(1'b1, 300); watch(1000); join
    chk(ne, 0);
    fork src_u.pulse(1'b1, 1100); watch(1800); join
    chk(ne >= 101 && ne <= 201, 1);
    fork src_u.pulse(1'b1, 1100); watch(4000); join
    chk(ne, 0);
    axi_wr(8'h04, 32'h0);
    axi_wr(8'h08, 32'h0);
    for (int i = 0; i < 3; i++) begin
      v = 32'h43 | ((i == 1) ? 32'h20 : 32'h0) | ((i == 2) ? 32'h80 : 32'h0);
      axi_wr(8'h00, v & 32'hfffffffe);
      axi_wr(8'h00, v);
      fork src_u.pulse(i == 0, 1200); watch(1600); join
      chk(ne >= 1195 && ne <= 1205, 1);
    end
    axi_wr(8'h00, 32'h0003000f);
    fork axi_wr(8'h14, 32'h00030000); watch(300); join
    chk({r2, ne}, 0);
    fork axi_wr(8'h14, 32'h00030001); watch(400); join
    chk({r2, n2}, {32'h3, 32'h9});
    chk(ne >= 101 && ne <= 201, 1);
    axi_wr(8'h14, 32'h00010000);
    fork axi_wr(8'h14, 32'h00010005); watch(400); join
    chk({r2, n2}, {32'h1, 32'd30});
    axi_wr(8'h00, 32'h00000012);
    axi_wr(8'h00, 32'h00000013);
    fork lnk_u.pulse(1'b1, 100); watch(400); join
    chk({ns, ne >= 101 && ne <= 201}, {32'h1, 1'b1});
    axi_wr(8'h00, 32'h00004a00);
    watch(10);
    chk(n1, 10);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    axi_rd(8'h10);
    chk({resp, dat, o1}, {2'h0, 32'h000003e8, 1'b0});
    report_and_stop;
  end
endmodule
bind ctp_trigger ctp_trigger_chk chk_u (.*);
